// ===== adc_limit_alert_unit.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Pin mode bits: 00 no signal, 01 busy, 10 alert.
// - Writing 11 to pin mode clears pin, result flag, whole status.
// - After that clear the mode bits read back as 10.
// - Delay bits postpone sampling and bit trials while the bus is busy.
// - Both delay bits reset to zero; writing zero turns delays off.
// - Bit-trial delay beyond one microsecond abandons the conversion.
// - Power-down bits 7, 5, 4: chip, ADC buffer, DAC buffer; 6 reserved.
// - Power-down bits 3, 2, 1: temp sensor, current two, current one.
// - Both reference buffer power-down bits are set at reset.
// - Bit 0 tristates outputs and self-sets on die overheat.
// - Limits hold twelve bits, alert flag at bit 15, 14:12 zero.
// - Channels one to four single-ended: low 000, high FFF.
// - Channels one to four differential: high 7FF, low 800.
// - Current channels use two's complement limits 7FF and 800.
// - Temperature channels use eleven-bit two's complement limits 3FF and 400.
// - Alert above high limit, released hysteresis below it.
// - Alert below low limit, released hysteresis above it.
// - Temperature limit and hysteresis bit 11 held at zero.
// - Each channel has a hysteresis register, twelve bits plus flag.
// - Hysteresis resets to 8 LSB, or 32 LSB for temperature.
// - All-ones hysteresis turns limits into max and min capture.
// - Sixteen-bit registers travel upper byte first, then lower.
// - Configuration bit 0 picks the alert pin polarity.
// - Writing all ones to alert status clears it.
module adc_limit_alert_unit (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   input wire logic conv_start,
   input wire logic conv_valid,
   input wire logic [3:0] conv_chan,
   input wire logic [11:0] conv_result,
   input wire logic bus_active,
   input wire logic die_overtemp,
   output logic sample_hold,
   output logic trial_hold,
   output logic conv_abort,
   output logic alert_pin,
   output logic [7:0] power_down
);
   localparam int N = alert_pkg::CH_N;

   typedef struct packed {
      logic [15:0] cfg;
      logic [7:0] pd;
      logic [2*N-1:0] stat;
      logic busy;
      logic [7:0] tcnt;
      logic abort;
      logic [11:0] result;
      logic [3:0] chan;
      logic [2:0] sync;
      logic ot;
      logic pin;
      logic [15:0] rdata;
   } top_state_s;

   localparam top_state_s TOP_RST = '{cfg: alert_pkg::CFG_RST,
      pd: alert_pkg::PD_RST, default: '0};

   top_state_s s_q, s_d;

   logic [N-1:0] hi_v, lo_v, evh_v, evl_v;
   logic [11:0] up_a [N];
   logic [11:0] lo_a [N];
   logic [11:0] hy_a [N];
   logic wr_cfg, wr_pd, stat_all1, clr_cfg, clr_stat, alert_any;
   logic pin_act;
   logic [1:0] mode;
   logic [2*N-1:0] ev_stat;

   // Pointer value of a limit register: k 0 upper, 1 lower, 2 hysteresis
   function automatic logic [7:0] lim_addr(input int i, input int k);
      return alert_pkg::ADDR_LIM_BASE + 8'(3 * i + k);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Write strobes shared by the channels and the control state
   always_comb begin
      wr_cfg = 1'b0;
      wr_pd = 1'b0;
      stat_all1 = 1'b0;
      if (reg_wr && reg_addr == alert_pkg::ADDR_CFG) begin
         wr_cfg = 1'b1;
      end else if (reg_wr && reg_addr == alert_pkg::ADDR_PWR) begin
         wr_pd = 1'b1;
      end else if (reg_wr && (reg_addr == alert_pkg::ADDR_STAT_A ||
            reg_addr == alert_pkg::ADDR_STAT_B ||
            reg_addr == alert_pkg::ADDR_STAT_C)) begin
         stat_all1 = reg_wdata[7:0] == alert_pkg::STAT_ALL_ONES;
      end
   end

   // clear request from mode bits 11
   assign clr_cfg = wr_cfg &&
      reg_wdata[alert_pkg::CFG_PIN_LSB +: 2] == alert_pkg::PIN_CLEAR;
   assign clr_stat = clr_cfg || stat_all1;

   ////////////////////////////////////////////////////////////////////
   // Channel instances: 1-4 voltage, 5-6 current, 7-9 temperature
   for (genvar i = 0; i < N; i++) begin : g_ch
      localparam bit IS_V = i < 4;
      localparam bit IS_T = i >= 6;
      chan_if cb ();
      limit_channel #(
         .HI_SE(IS_V ? alert_pkg::SE_HI :
            IS_T ? alert_pkg::TEMP_HI : alert_pkg::TC_HI),
         .LO_SE(IS_V ? alert_pkg::SE_LO :
            IS_T ? alert_pkg::TEMP_LO : alert_pkg::TC_LO),
         .HI_DIF(IS_T ? alert_pkg::TEMP_HI : alert_pkg::TC_HI),
         .LO_DIF(IS_T ? alert_pkg::TEMP_LO : alert_pkg::TC_LO),
         .HYS0(IS_T ? alert_pkg::HYS_TEMP_RST : alert_pkg::HYS_RST),
         .MASK(IS_T ? alert_pkg::TEMP_MASK : alert_pkg::FULL_MASK),
         .SIGNED(!IS_V),
         .SIGN_BIT(IS_T ? 10 : 11)
      ) u_ch (
         .clk(clk),
         .reset(reset),
         .bus(cb.chan)
      );
      assign cb.wr_up = reg_wr && reg_addr == lim_addr(i, 0);
      assign cb.wr_lo = reg_wr && reg_addr == lim_addr(i, 1);
      assign cb.wr_hy = reg_wr && reg_addr == lim_addr(i, 2);
      assign cb.wdata = reg_wdata[11:0];
      assign cb.result = conv_result;
      assign cb.res_valid = conv_valid && conv_chan == 4'(i);
      assign cb.clear = clr_cfg;
      // differential defaults follow the pair's mode bit
      if (i < 2) begin : g_d12
         assign cb.diff = reg_wdata[alert_pkg::CFG_DIFF12];
         assign cb.load_def = wr_cfg && reg_wdata[alert_pkg::CFG_DIFF12]
            != s_q.cfg[alert_pkg::CFG_DIFF12];
      end else if (i < 4) begin : g_d34
         assign cb.diff = reg_wdata[alert_pkg::CFG_DIFF34];
         assign cb.load_def = wr_cfg && reg_wdata[alert_pkg::CFG_DIFF34]
            != s_q.cfg[alert_pkg::CFG_DIFF34];
      end else begin : g_nodiff
         // No differential mode on current or temperature inputs
         assign cb.diff = 1'b0;
         assign cb.load_def = 1'b0;
      end
      assign hi_v[i] = cb.alert_hi;
      assign lo_v[i] = cb.alert_lo;
      assign evh_v[i] = cb.ev_hi;
      assign evl_v[i] = cb.ev_lo;
      assign up_a[i] = cb.upper;
      assign lo_a[i] = cb.lower;
      assign hy_a[i] = cb.hyst;
      // Status layout: even bit low alert, odd bit high alert
      assign ev_stat[2*i] = cb.ev_lo;
      assign ev_stat[2*i+1] = cb.ev_hi;
   end

   assign alert_any = |(hi_v | lo_v);
   assign mode = s_q.cfg[alert_pkg::CFG_PIN_LSB +: 2];

   ////////////////////////////////////////////////////////////////////
   // Next control state
   always_comb begin
      s_d = s_q;
      // Configuration write
      if (wr_cfg) begin
         s_d.cfg = reg_wdata & alert_pkg::CFG_MASK;
         if (clr_cfg) begin
            s_d.cfg[alert_pkg::CFG_PIN_LSB +: 2] = alert_pkg::PIN_ALERT;
         end
      end
      // software bits, reserved bit 6 forced low
      // sensor and current channel power-down bits
      if (wr_pd) begin
         s_d.pd = reg_wdata[7:0] & alert_pkg::PD_MASK;
      end
      // overheat forces tristate, beating any write
      if (s_q.ot) begin
         s_d.pd[alert_pkg::PD_OUTPUT_HIGHZ_BIT] = 1'b1;
      end
      // Overheat level from the die sensor, three-stage synchroniser
      s_d.sync = {s_q.sync[1:0], die_overtemp};
      if (s_q.sync[1] == s_q.sync[2]) begin
         s_d.ot = s_q.sync[2];
      end
      // sticky status, a same-cycle event survives the clear
      s_d.stat = (clr_stat ? '0 : s_q.stat) | ev_stat;
      // count stretched bit trials; past the limit, give up
      s_d.abort = 1'b0;
      if (s_q.busy && trial_hold) begin
         if (s_q.tcnt == alert_pkg::TRIAL_CYC) begin
            s_d.busy = 1'b0;
            s_d.abort = 1'b1;
            s_d.tcnt = '0;
         end else begin
            s_d.tcnt = s_q.tcnt + 8'h01;
         end
      end else begin
         s_d.tcnt = '0;
      end
      if (conv_valid) begin
         s_d.busy = 1'b0;
         s_d.result = conv_result;
         s_d.chan = conv_chan;
      end
      if (conv_start) begin
         s_d.busy = 1'b1;
      end
      // pin function from the mode bits
      case (mode)
         alert_pkg::PIN_BUSY: pin_act = s_q.busy;
         alert_pkg::PIN_ALERT: pin_act = alert_any;
         default: pin_act = 1'b0;
      endcase
      // polarity: bit 0 high means active high
      s_d.pin = s_q.cfg[alert_pkg::CFG_POL] ? pin_act : ~pin_act;
      // result and limit read frame: flag, three zeros, twelve bits
      // serial engine ships [15:8] first, then [7:0]
      s_d.rdata = 16'h0000;
      if (reg_addr == alert_pkg::ADDR_RESULT) begin
         s_d.rdata = {s_q.chan < 4'(N) &&
            (hi_v[s_q.chan] | lo_v[s_q.chan]), 3'h0, s_q.result};
      end else if (reg_addr == alert_pkg::ADDR_CFG) begin
         s_d.rdata = s_q.cfg;
      end else if (reg_addr == alert_pkg::ADDR_PWR) begin
         s_d.rdata = {8'h00, s_q.pd};
      end else if (reg_addr == alert_pkg::ADDR_STAT_A) begin
         s_d.rdata = {8'h00, s_q.stat[7:0]};
      end else if (reg_addr == alert_pkg::ADDR_STAT_B) begin
         s_d.rdata = {12'h000, s_q.stat[11:8]};
      end else if (reg_addr == alert_pkg::ADDR_STAT_C) begin
         s_d.rdata = {10'h000, s_q.stat[17:12]};
      end
      for (int i = 0; i < N; i++) begin
         if (reg_addr == lim_addr(i, 0)) begin
            s_d.rdata = {hi_v[i] | lo_v[i], 3'h0, up_a[i]};
         end
         if (reg_addr == lim_addr(i, 1)) begin
            s_d.rdata = {hi_v[i] | lo_v[i], 3'h0, lo_a[i]};
         end
         if (reg_addr == lim_addr(i, 2)) begin
            s_d.rdata = {hi_v[i] | lo_v[i], 3'h0, hy_a[i]};
         end
      end
   end

   // Single register stage for all control state
   always_ff @(posedge clk) begin
      if (reset) begin
         s_q <= TOP_RST;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs
   // hold requests only while the bus talks
   assign sample_hold = s_q.cfg[alert_pkg::CFG_SAMPLE] && bus_active;
   assign trial_hold = s_q.cfg[alert_pkg::CFG_TRIAL] && bus_active;
   assign conv_abort = s_q.abort;
   assign alert_pin = s_q.pin;
   assign power_down = s_q.pd;
   assign reg_rdata = s_q.rdata;

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb_main @(posedge clk); endclocking
   default disable iff (reset);

   a_pin_off: assert property (
      mode == alert_pkg::PIN_OFF |=> alert_pin == !$past(s_q.cfg[0]))
      else $error("pin active in off mode");
   a_clear_status: assert property (
      clr_cfg && ev_stat == '0 |=> s_q.stat == '0 && (hi_v | lo_v) == '0)
      else $error("clear left alerts");
   a_clear_readback: assert property (
      clr_cfg |=> mode == alert_pkg::PIN_ALERT ##1
         (reg_addr != alert_pkg::ADDR_CFG || s_q.rdata[2:1] == 2'b10))
      else $error("clear readback wrong");
   // Holds are combinational so the core sees bus traffic at once
   a_delay_gate: assert property (
      wr_cfg && reg_wdata[alert_pkg::CFG_TRIAL] ##1 bus_active
      |-> trial_hold)
      else $error("trial not held");
   a_sample_gate: assert property (
      wr_cfg && reg_wdata[alert_pkg::CFG_SAMPLE] ##1 bus_active
      |-> sample_hold)
      else $error("sample not held");
   a_delay_off: assert property (
      wr_cfg && reg_wdata[alert_pkg::CFG_SAMPLE -: 2] == 2'b00
      |=> !sample_hold && !trial_hold)
      else $error("delay active while off");
   a_trial_abort: assert property (
      s_q.busy && trial_hold && s_q.tcnt == alert_pkg::TRIAL_CYC
      && !conv_start |=> conv_abort && !s_q.busy)
      else $error("long trial not aborted");
   a_pd_reserved: assert property (
      wr_pd |=> power_down[6] == 1'b0 &&
         power_down[5:1] == $past(reg_wdata[5:1]))
      else $error("power-down write wrong");
   a_overtemp_highz: assert property (
      $rose(s_q.ot) |-> ##[1:2] power_down[0])
      else $error("overheat not latched");
   a_busy_pin: assert property (
      mode == alert_pkg::PIN_BUSY && s_q.cfg[0] && $rose(s_q.busy)
      && !wr_cfg |=> alert_pin)
      else $error("busy not shown");
   a_limit_zero: assert property (
      reg_addr >= alert_pkg::ADDR_LIM_BASE |=> s_q.rdata[14:12] == 3'h0)
      else $error("limit gap bits set");
   a_stat_ones: assert property (
      stat_all1 && ev_stat == '0 |=> s_q.stat == '0)
      else $error("status ones write kept bits");
   a_alert_pin: assert property (
      mode == alert_pkg::PIN_ALERT
      |=> alert_pin == ($past(alert_any) == $past(s_q.cfg[0])))
      else $error("alert pin level wrong");
   // Overheat is a level, so the tristate bit must hold while it lasts
   a_hot_tristate: assert property (
      s_q.ot |=> power_down[alert_pkg::PD_OUTPUT_HIGHZ_BIT])
      else $error("overheat tristate dropped");
   a_busy_clear: assert property (
      conv_valid && !conv_start |=> !s_q.busy)
      else $error("busy left after result");

   c_alert_raise: cover property (mode == alert_pkg::PIN_ALERT
      && $rose(alert_any));
   c_trial_abort: cover property (conv_abort);
   c_clear_event: cover property (clr_cfg && s_q.stat != '0);
   c_stat_ones: cover property (stat_all1 ##1 conv_valid);
endmodule // adc_limit_alert_unit
`default_nettype wire

// ===== alert_pkg.sv
`default_nettype none
package alert_pkg;
   localparam int CH_N = 9;
   // Register pointer values
   localparam logic [7:0] ADDR_RESULT = 8'h01;
   localparam logic [7:0] ADDR_CFG = 8'h02;
   localparam logic [7:0] ADDR_STAT_A = 8'h04;
   localparam logic [7:0] ADDR_STAT_B = 8'h05;
   localparam logic [7:0] ADDR_STAT_C = 8'h06;
   localparam logic [7:0] ADDR_PWR = 8'h0A;
   localparam logic [7:0] ADDR_LIM_BASE = 8'h10;
   // Configuration fields
   localparam int CFG_POL = 0;
   localparam int CFG_PIN_LSB = 1;
   localparam int CFG_DIFF12 = 8;
   localparam int CFG_DIFF34 = 9;
   localparam int CFG_TRIAL = 13;
   localparam int CFG_SAMPLE = 14;
   localparam logic [15:0] CFG_RST = 16'h0000;
   localparam logic [15:0] CFG_MASK = 16'h7FFF;
   localparam logic [1:0] PIN_OFF = 2'h0;
   localparam logic [1:0] PIN_BUSY = 2'h1;
   localparam logic [1:0] PIN_ALERT = 2'h2;
   localparam logic [1:0] PIN_CLEAR = 2'h3;
   // Power-down fields
   localparam int PD_OUTPUT_HIGHZ_BIT = 0;
   localparam logic [7:0] PD_RST = 8'h30;
   localparam logic [7:0] PD_MASK = 8'hBF;
   // Limit and hysteresis fields
   localparam int LIM_FLAG = 15;
   localparam logic [11:0] FULL_MASK = 12'hFFF;
   localparam logic [11:0] TEMP_MASK = 12'h7FF;
   localparam logic [11:0] SE_HI = 12'hFFF;
   localparam logic [11:0] SE_LO = 12'h000;
   localparam logic [11:0] TC_HI = 12'h7FF;
   localparam logic [11:0] TC_LO = 12'h800;
   localparam logic [11:0] TEMP_HI = 12'h3FF;
   localparam logic [11:0] TEMP_LO = 12'h400;
   localparam logic [11:0] HYS_RST = 12'h008;
   localparam logic [11:0] HYS_TEMP_RST = 12'h020;
   localparam logic [7:0] STAT_ALL_ONES = 8'hFF;
   // Bit-trial stretch limit
   localparam int CLK_KHZ = 40000;
   localparam int TRIAL_MAX_NS = 1000;
   localparam logic [7:0] TRIAL_CYC = 8'(TRIAL_MAX_NS * CLK_KHZ / 1000000);
endpackage
`default_nettype wire

// ===== chan_if.sv
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
   logic wr_up, wr_lo, wr_hy, load_def, diff, res_valid, clear;
   logic [11:0] wdata, result, upper, lower, hyst;
   logic alert_hi, alert_lo, ev_hi, ev_lo;
   modport ctrl (output wr_up, wr_lo, wr_hy, load_def, diff, res_valid,
      clear, wdata, result, input upper, lower, hyst, alert_hi, alert_lo,
      ev_hi, ev_lo);
   modport chan (input wr_up, wr_lo, wr_hy, load_def, diff, res_valid,
      clear, wdata, result, output upper, lower, hyst, alert_hi, alert_lo,
      ev_hi, ev_lo);
endinterface
`default_nettype wire

// ===== limit_channel.sv
`timescale 1ns/1ps
`default_nettype none
module limit_channel #(
   parameter logic [11:0] HI_SE = 12'hFFF,
   parameter logic [11:0] LO_SE = 12'h000,
   parameter logic [11:0] HI_DIF = 12'h7FF,
   parameter logic [11:0] LO_DIF = 12'h800,
   parameter logic [11:0] HYS0 = 12'h008,
   parameter logic [11:0] MASK = 12'hFFF,
   parameter bit SIGNED = 1'b0,
   parameter int SIGN_BIT = 11
) (
   input wire logic clk,
   input wire logic reset,
   chan_if.chan bus
);
   typedef struct packed {
      logic [11:0] upper;
      logic [11:0] lower;
      logic [11:0] hyst;
      logic hi;
      logic lo;
   } ch_state_s;
   localparam ch_state_s RST = '{HI_SE, LO_SE, HYS0, 1'b0, 1'b0};
   ch_state_s s_q, s_d;
   logic [11:0] kr, ku, kl, res_m;
   logic minmax, hi_set, lo_set, hi_rel, lo_rel;

   // Offset binary makes signed formats compare as plain unsigned
   function automatic logic [11:0] key(input logic [11:0] v);
      logic [11:0] k;
      k = v & MASK;
      if (SIGNED) k[SIGN_BIT] = ~k[SIGN_BIT];
      return k;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Next state: compare, track, write
   always_comb begin
      res_m = bus.result & MASK;
      kr = key(bus.result);
      ku = key(s_q.upper);
      kl = key(s_q.lower);
      minmax = (s_q.hyst == MASK);
      hi_set = kr > ku;
      lo_set = kr < kl;
      // 13-bit sums so a large hysteresis cannot wrap
      hi_rel = ({1'b0, kr} + {1'b0, s_q.hyst}) <= {1'b0, ku};
      lo_rel = {1'b0, kr} >= ({1'b0, kl} + {1'b0, s_q.hyst});
      s_d = s_q;
      bus.ev_hi = 1'b0;
      bus.ev_lo = 1'b0;
      if (bus.res_valid) begin
         if (minmax) begin
            if (hi_set) s_d.upper = res_m;
            if (lo_set) s_d.lower = res_m;
            s_d.hi = 1'b0;
            s_d.lo = 1'b0;
         end else begin
            bus.ev_hi = hi_set & ~s_q.hi;
            bus.ev_lo = lo_set & ~s_q.lo;
            s_d.hi = s_q.hi ? ~hi_rel : hi_set;
            s_d.lo = s_q.lo ? ~lo_rel : lo_set;
         end
      end
      if (bus.clear) begin
         s_d.hi = s_d.hi & bus.ev_hi;
         s_d.lo = s_d.lo & bus.ev_lo;
      end
      // mask drops the diode flag position
      if (bus.wr_up) s_d.upper = bus.wdata & MASK;
      if (bus.wr_lo) s_d.lower = bus.wdata & MASK;
      if (bus.wr_hy) s_d.hyst = bus.wdata & MASK;
      if (bus.load_def) begin
         s_d.upper = bus.diff ? HI_DIF : HI_SE;
         s_d.lower = bus.diff ? LO_DIF : LO_SE;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_q <= RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign bus.upper = s_q.upper;
   assign bus.lower = s_q.lower;
   assign bus.hyst = s_q.hyst;
   assign bus.alert_hi = s_q.hi;
   assign bus.alert_lo = s_q.lo;

   a_high_raise: assert property (@(posedge clk) disable iff (reset)
      bus.res_valid && !minmax && hi_set && !bus.wr_hy
      && !(bus.clear && s_q.hi) |=> s_q.hi)
      else $error("high alert not raised");
   a_minmax_track: assert property (@(posedge clk) disable iff (reset)
      bus.res_valid && minmax && lo_set && !bus.wr_lo && !bus.load_def
      |=> s_q.lower == $past(res_m) && !s_q.lo)
      else $error("minimum not captured");
endmodule // limit_channel
`default_nettype wire

// ===== host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Register master in place of the serial engine, one byte pair a transfer
module host_model (
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata
);
   // Idle bus at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] hi,
         input logic [7:0] lo);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = {hi, lo};
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_wdata = ~reg_wdata; // Data is not held once released
   endtask
   // upper byte first
   // Two edges pass so the registered answer has landed
   task automatic rd(input logic [7:0] a, output logic [7:0] hi,
         output logic [7:0] lo);
      @(negedge clk);
      reg_addr = a;
      repeat (2) @(negedge clk);
      hi = reg_rdata[15:8];
      lo = reg_rdata[7:0];
   endtask
endmodule // host_model
`default_nettype wire

// ===== adc_limit_alert_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_limit_alert_unit_bench;
   logic clk;
   logic reset;
   logic conv_start;
   logic conv_valid;
   logic bus_active;
   logic die_overtemp;
   logic [3:0] conv_chan;
   logic [11:0] conv_result;
   wire logic [7:0] reg_addr;
   wire logic reg_wr;
   wire logic [15:0] reg_wdata;
   wire logic [15:0] reg_rdata;
   wire logic sample_hold;
   wire logic trial_hold;
   wire logic conv_abort;
   wire logic alert_pin;
   wire logic [7:0] power_down;
   int failures;
   int checks;
   localparam logic [7:0] CFG = alert_pkg::ADDR_CFG;

   ////////////////////////////////////////////////////////////////////
   // Clock and instances
   always #12.5 clk = ~clk;

   host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   adc_limit_alert_unit uut (.clk(clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .conv_start(conv_start),
      .conv_valid(conv_valid), .conv_chan(conv_chan),
      .conv_result(conv_result), .bus_active(bus_active),
      .die_overtemp(die_overtemp), .sample_hold(sample_hold),
      .trial_hold(trial_hold), .conv_abort(conv_abort),
      .alert_pin(alert_pin), .power_down(power_down));

   ////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic chk(input string what, input logic [15:0] seen,
         input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [15:0] exp,
         input string what);
      logic [7:0] h;
      logic [7:0] l;
      host.rd(a, h, l);
      chk(what, {h, l}, exp);
   endtask
   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      host.wr(a, v[15:8], v[7:0]);
   endtask
   // Result pulse; returns once the pin has followed the new state
   task automatic conv(input logic [3:0] ch, input logic [11:0] res);
      @(negedge clk);
      conv_valid = 1'b1;
      conv_chan = ch;
      conv_result = res;
      @(negedge clk);
      conv_valid = 1'b0;
      conv_result = ~res;
      @(negedge clk);
   endtask
   task automatic final_report;
      $display("Checks %0d mismatches %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset;
      chk("power_down", {8'h00, power_down}, 16'h0030);
      chk("idle pin", {15'h0, alert_pin}, 16'h0001);
      rdc(CFG, 16'h0000, "config");
      rdc(8'h10, 16'h0FFF, "ch1 upper");
      rdc(8'h11, 16'h0000, "ch1 lower");
      rdc(8'h12, 16'h0008, "ch1 hyst");
      rdc(8'h1C, 16'h07FF, "cur1 upper");
      rdc(8'h1D, 16'h0800, "cur1 lower");
      rdc(8'h22, 16'h03FF, "temp1 upper");
      rdc(8'h23, 16'h0400, "temp1 lower");
      rdc(8'h24, 16'h0020, "temp1 hyst");
      wr16(CFG, 16'h0300);
      rdc(8'h10, 16'h07FF, "diff upper");
      rdc(8'h11, 16'h0800, "diff lower");
      rdc(8'h16, 16'h07FF, "ch3 diff upper");
      wr16(CFG, 16'h0000);
      rdc(8'h10, 16'h0FFF, "se upper again");
      wr16(8'h22, 16'h0FFF);
      rdc(8'h22, 16'h07FF, "temp bit11");
      $display("Test reset done");
   endtask

   task automatic t_power;
      wr16(alert_pkg::ADDR_PWR, 16'h00FF);
      chk("pd all", {8'h00, power_down}, 16'h00BF);
      wr16(alert_pkg::ADDR_PWR, 16'h000E);
      rdc(alert_pkg::ADDR_PWR, 16'h000E, "pd low");
      die_overtemp = 1'b1;
      repeat (6) @(negedge clk);
      chk("pd hot", {15'h0, power_down[0]}, 16'h0001);
      die_overtemp = 1'b0;
      repeat (6) @(negedge clk);
      wr16(alert_pkg::ADDR_PWR, 16'h0030);
      $display("Test power done");
   endtask

   // Upper 100, lower 40, hysteresis 8 on channel one
   task automatic t_alert;
      wr16(CFG, 16'h0005);
      // limits set after the last input mode change
      wr16(8'h10, 16'h0100);
      wr16(8'h11, 16'h0040);
      conv(4'h0, 12'h101);
      chk("hi set", {15'h0, alert_pin}, 16'h0001);
      rdc(alert_pkg::ADDR_RESULT, 16'h8101, "result");
      conv(4'h0, 12'h0FA);
      chk("hi hold", {15'h0, alert_pin}, 16'h0001);
      conv(4'h0, 12'h0F8);
      chk("hi free", {15'h0, alert_pin}, 16'h0000);
      conv(4'h0, 12'h03F);
      chk("lo set", {15'h0, alert_pin}, 16'h0001);
      conv(4'h0, 12'h047);
      chk("lo hold", {15'h0, alert_pin}, 16'h0001);
      conv(4'h0, 12'h048);
      chk("lo free", {15'h0, alert_pin}, 16'h0000);
      conv(4'h0, 12'h03F);
      wr16(CFG, 16'h0007);
      @(negedge clk);
      chk("clr pin", {15'h0, alert_pin}, 16'h0000);
      rdc(CFG, 16'h0005, "cfg after clr");
      rdc(alert_pkg::ADDR_STAT_A, 16'h0000, "stat clr");
      conv(4'h0, 12'h03F);
      rdc(alert_pkg::ADDR_STAT_A, 16'h0001, "stat lo");
      wr16(alert_pkg::ADDR_STAT_A, 16'h00FF);
      rdc(alert_pkg::ADDR_STAT_A, 16'h0000, "stat ones");
      wr16(8'h12, 16'h0FFF);
      conv(4'h0, 12'h456);
      conv(4'h0, 12'h012);
      rdc(8'h10, 16'h0456, "max");
      rdc(8'h11, 16'h0012, "min");
      wr16(CFG, 16'h0004);
      @(negedge clk);
      chk("low pol", {15'h0, alert_pin}, 16'h0001);
      $display("Test alert done");
   endtask

   task automatic t_busy;
      wr16(CFG, 16'h0003);
      conv_start = 1'b1;
      @(negedge clk);
      conv_start = 1'b0;
      @(negedge clk);
      chk("busy on", {15'h0, alert_pin}, 16'h0001);
      conv(4'h1, 12'h200);
      chk("busy off", {15'h0, alert_pin}, 16'h0000);
      $display("Test busy done");
   endtask

   // Bus held busy so the trial stretch runs past its limit
   task automatic t_abort;
      int n;
      wr16(CFG, 16'h6003);
      bus_active = 1'b1;
      @(negedge clk);
      chk("sample hold", {15'h0, sample_hold}, 16'h0001);
      chk("trial hold", {15'h0, trial_hold}, 16'h0001);
      conv_start = 1'b1;
      @(negedge clk);
      conv_start = 1'b0;
      n = 0;
      while (conv_abort !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      if (n >= 100) begin
         failures++;
         $display("Error abort wait ran out");
         final_report();
      end
      chk("abort cycles", 16'(n),
         {8'h00, alert_pkg::TRIAL_CYC} + 16'h0001);
      // Bus kept busy so only the cleared bits can drop the holds
      wr16(CFG, 16'h0000);
      chk("holds off", {14'h0, sample_hold, trial_hold}, 16'h0000);
      bus_active = 1'b0;
      $display("Test abort done");
   endtask

   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      conv_start = 1'b0;
      conv_valid = 1'b0;
      bus_active = 1'b0;
      die_overtemp = 1'b0;
      conv_chan = 4'h0;
      conv_result = 12'h000;
      failures = 0;
      checks = 0;
      repeat (4) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      t_reset();
      t_power();
      t_alert();
      t_busy();
      t_abort();
      final_report();
   end
endmodule // adc_limit_alert_unit_bench
`default_nettype wire
